// ---- logic/lcd_bias_i2c_register_port.sv ----
// two-wire slave port and register bank of a dual display bias supply
`timescale 1ns/100ps
`default_nettype none
`include "lcd_bias_cfg.svh"

module lcd_bias_i2c_register_port (
   // system clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // two-wire link, open drain data
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // settings to the analog side
   output logic [4:0] positive_level_code,
   output logic [4:0] negative_level_code,
   output logic positive_discharge_enable,
   output logic negative_discharge_enable,
   output logic application_mode_select
);

   // ******************************************************
   // read-back image
   // ******************************************************

   // reserved and unmapped read as zero
   function automatic logic [7:0] reg_read(input logic [7:0] offset,
                                           input logic [12:0] image);
      logic [7:0] value;
      value = 8'h00;
      if (offset == `OFFSET_POSITIVE_LEVEL) value = {3'h0, image[4:0]};
      if (offset == `OFFSET_NEGATIVE_LEVEL) value = {3'h0, image[9:5]};
      if (offset == `OFFSET_DISCHARGE_APP) begin
         value[`BIT_APPLICATION_MODE] = image[12];
         value[`BIT_POSITIVE_DISCHARGE] = image[11];
         value[`BIT_NEGATIVE_DISCHARGE] = image[10];
      end
      return value;
   endfunction : reg_read

   function automatic logic [7:0] step_pointer(input logic [7:0] ptr);
      return ptr + 8'h01;
   endfunction : step_pointer

   wire logic [12:0] reg_image;

   // stored settings packed for the link engine
   assign reg_image = {application_mode_select, positive_discharge_enable,
                       negative_discharge_enable, negative_level_code,
                       positive_level_code};

   // ******************************************************
   // start and stop detection, system clock
   // ******************************************************

   logic scl_low_sync;
   logic sda_low_sync;
   wire logic scl_sync;
   wire logic sda_sync;
   logic sda_prev_reg;
   logic restart_reg;
   wire logic start_seen;
   wire logic stop_seen;
   wire logic link_clear_n;

   bit_sync scl_sync_inst (
      .clock(clock),
      .reset_n(reset_n),
      .async_in(~scl),
      .sync_out(scl_low_sync)
   );

   bit_sync sda_sync_inst (
      .clock(clock),
      .reset_n(reset_n),
      .async_in(~sda_in),
      .sync_out(sda_low_sync)
   );

   // inverted syncs rest at the idle level through reset, no false stop
   assign scl_sync = ~scl_low_sync;
   assign sda_sync = ~sda_low_sync;
   // data edges while the clock line is high
   assign start_seen = scl_sync & sda_prev_reg & ~sda_sync;
   assign stop_seen = scl_sync & ~sda_prev_reg & sda_sync;

   // one-cycle restart pulse, glitch free from a flop
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         sda_prev_reg <= 1'b1;
         restart_reg <= 1'b0;
      end else begin
         sda_prev_reg <= sda_sync;
         restart_reg <= start_seen | stop_seen;
      end
   end

   // clears the byte engine; the link clock is high and idle meanwhile
   assign link_clear_n = reset_n & ~restart_reg;

   // ******************************************************
   // byte engine, link clock
   // ******************************************************

   lcd_bias_pkg::link_phase_t phase_reg;
   lcd_bias_pkg::link_phase_t phase_next;
   logic [3:0] bit_cnt_reg;
   logic [3:0] bit_cnt_next;
   logic [7:0] rx_shift_reg;
   logic [7:0] tx_shift_reg;
   logic [7:0] tx_next;
   logic [7:0] pointer_reg;
   logic [7:0] pointer_next;
   logic ack_pending_reg;
   logic ack_next;
   logic sda_low_reg;
   logic [7:0] wr_offset_reg;
   logic [7:0] wr_value_reg;
   logic wr_toggle_reg;
   wire logic [7:0] byte_in;
   wire logic last_bit;
   wire logic ack_clock;
   wire logic addr_match;
   wire logic master_ack;
   wire logic wr_event;
   wire logic drive_want;

   assign byte_in = {rx_shift_reg[6:0], sda_in};
   assign last_bit = bit_cnt_reg == `LAST_DATA_BIT;
   assign ack_clock = bit_cnt_reg == `ACK_BIT_INDEX;
   assign addr_match = byte_in[7:1] == `SLAVE_ADDRESS;
   assign master_ack = ~sda_in;
   assign wr_event = (phase_reg == lcd_bias_pkg::PHASE_WDATA) & last_bit;

   // next state of the byte engine
   always_comb begin
      phase_next = phase_reg;
      pointer_next = pointer_reg;
      ack_next = ack_pending_reg & ~ack_clock;
      bit_cnt_next = ack_clock ? 4'h0 : bit_cnt_reg + 4'h1;
      tx_next = tx_shift_reg;
      // next read bit moves to the top
      if (!ack_clock && phase_reg == lcd_bias_pkg::PHASE_RDATA)
         tx_next = {tx_shift_reg[6:0], 1'b1};
      case (phase_reg)
         lcd_bias_pkg::PHASE_ADDR: begin
            if (last_bit && addr_match) begin
               ack_next = 1'b1;
               phase_next = byte_in[0] ? lcd_bias_pkg::PHASE_RD_START
                                       : lcd_bias_pkg::PHASE_REG;
            end else if (last_bit) begin
               phase_next = lcd_bias_pkg::PHASE_IGNORE;
            end
         end
         lcd_bias_pkg::PHASE_REG: begin
            if (last_bit) begin
               ack_next = 1'b1;
               pointer_next = byte_in;
               phase_next = lcd_bias_pkg::PHASE_WDATA;
            end
         end
         lcd_bias_pkg::PHASE_WDATA: begin
            if (last_bit) begin
               ack_next = 1'b1;
               pointer_next = step_pointer(pointer_reg);
            end
         end
         lcd_bias_pkg::PHASE_RD_START: begin
            if (ack_clock) begin
               tx_next = reg_read(pointer_reg, reg_image);
               phase_next = lcd_bias_pkg::PHASE_RDATA;
            end
         end
         lcd_bias_pkg::PHASE_RDATA: begin
            if (ack_clock && master_ack) begin
               pointer_next = step_pointer(pointer_reg);
               tx_next = reg_read(step_pointer(pointer_reg), reg_image);
            end else if (ack_clock) begin
               phase_next = lcd_bias_pkg::PHASE_IGNORE;
            end
         end
         lcd_bias_pkg::PHASE_IGNORE: begin
            phase_next = lcd_bias_pkg::PHASE_IGNORE;
         end
         default: begin
            phase_next = lcd_bias_pkg::PHASE_IGNORE;
         end
      endcase
   end

   // frame state, cleared at every start and stop
   always_ff @(posedge scl or negedge link_clear_n) begin
      if (!link_clear_n) begin
         phase_reg <= lcd_bias_pkg::PHASE_ADDR;
         bit_cnt_reg <= 4'h0;
         rx_shift_reg <= 8'h00;
         tx_shift_reg <= 8'hFF;
         ack_pending_reg <= 1'b0;
      end else begin
         phase_reg <= phase_next;
         bit_cnt_reg <= bit_cnt_next;
         rx_shift_reg <= ack_clock ? rx_shift_reg : byte_in;
         tx_shift_reg <= tx_next;
         ack_pending_reg <= ack_next;
      end
   end

   // pointer survives a repeated start; write word held for the crossing
   always_ff @(posedge scl or negedge reset_n) begin
      if (!reset_n) begin
         pointer_reg <= 8'h00;
         wr_offset_reg <= 8'h00;
         wr_value_reg <= 8'h00;
         wr_toggle_reg <= 1'b0;
      end else begin
         pointer_reg <= pointer_next;
         if (wr_event) begin
            wr_offset_reg <= pointer_reg;
            wr_value_reg <= byte_in;
            wr_toggle_reg <= ~wr_toggle_reg;
         end
      end
   end

   // ack and read bits pull low
   assign drive_want = (ack_clock & ack_pending_reg) |
                       ((phase_reg == lcd_bias_pkg::PHASE_RDATA) &
                        ~ack_clock & ~tx_shift_reg[7]);

   // data line changes only while the clock line is low
   always_ff @(negedge scl or negedge link_clear_n) begin
      if (!link_clear_n) sda_low_reg <= 1'b0;
      else sda_low_reg <= drive_want;
   end

   assign sda_out = 1'b0;
   assign sda_oe = sda_low_reg;

   // ******************************************************
   // write crossing into the system clock
   // ******************************************************

   logic wr_toggle_sync;
   logic wr_seen_reg;
   wire logic write_strobe;

   bit_sync wr_sync_inst (
      .clock(clock),
      .reset_n(reset_n),
      .async_in(wr_toggle_reg),
      .sync_out(wr_toggle_sync)
   );

   // offset and value stay still for nine link clocks after a toggle
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) wr_seen_reg <= 1'b0;
      else wr_seen_reg <= wr_toggle_sync;
   end

   assign write_strobe = wr_toggle_sync ^ wr_seen_reg;

   level_regs level_regs_inst (
      .clock(clock),
      .reset_n(reset_n),
      .write_strobe(write_strobe),
      .write_offset(wr_offset_reg),
      .write_value(wr_value_reg),
      .positive_level_code(positive_level_code),
      .negative_level_code(negative_level_code),
      .positive_discharge_enable(positive_discharge_enable),
      .negative_discharge_enable(negative_discharge_enable),
      .application_mode_select(application_mode_select)
   );

   // ******************************************************
   // checks
   // ******************************************************

   a_addr_nomatch: assert property (@(posedge scl) disable iff (!link_clear_n)
      phase_reg == lcd_bias_pkg::PHASE_ADDR && last_bit && !addr_match
      |=> !ack_pending_reg && phase_reg == lcd_bias_pkg::PHASE_IGNORE)
      else $error("foreign address was acknowledged");

   a_reg_byte_ack: assert property (@(posedge scl) disable iff (!link_clear_n)
      phase_reg == lcd_bias_pkg::PHASE_REG && last_bit
      |=> ack_pending_reg && pointer_reg == $past(byte_in))
      else $error("register address byte not taken or acked");

   a_write_multi: assert property (@(posedge scl) disable iff (!link_clear_n)
      phase_reg == lcd_bias_pkg::PHASE_WDATA && last_bit
      |=> ack_pending_reg ##1 phase_reg == lcd_bias_pkg::PHASE_WDATA)
      else $error("write data byte not acked");

   a_read_first: assert property (@(posedge scl) disable iff (!link_clear_n)
      phase_reg == lcd_bias_pkg::PHASE_RD_START && ack_clock
      |=> tx_shift_reg == reg_read($past(pointer_reg), $past(reg_image)))
      else $error("first read byte not loaded from pointer");

   a_read_nack_end: assert property (@(posedge scl) disable iff (!link_clear_n)
      phase_reg == lcd_bias_pkg::PHASE_RDATA && ack_clock && sda_in
      |=> phase_reg == lcd_bias_pkg::PHASE_IGNORE ##1 !sda_oe)
      else $error("read went on after master no-ack");

   a_ack_low: assert property (@(posedge scl) disable iff (!link_clear_n)
      ack_clock && ack_pending_reg |-> sda_oe && !sda_out)
      else $error("acknowledge clock without data line low");

   a_read_msb: assert property (@(posedge scl) disable iff (!link_clear_n)
      phase_reg == lcd_bias_pkg::PHASE_RDATA && !ack_clock
      |-> sda_oe == !tx_shift_reg[7])
      else $error("read bit on the line differs from shift top");

   a_ptr_advance: assert property (@(posedge scl) disable iff (!reset_n)
      wr_event |=> pointer_reg == step_pointer($past(pointer_reg)))
      else $error("pointer did not step after a data byte");

   a_pos_commit: assert property (@(posedge clock) disable iff (!reset_n)
      write_strobe && wr_offset_reg == `OFFSET_POSITIVE_LEVEL
      |=> positive_level_code == $past(wr_value_reg[4:0]))
      else $error("positive level write lost");

   a_ctl_commit: assert property (@(posedge clock) disable iff (!reset_n)
      write_strobe && wr_offset_reg == `OFFSET_DISCHARGE_APP
      |=> positive_discharge_enable == $past(wr_value_reg[1]) &&
          negative_discharge_enable == $past(wr_value_reg[0]))
      else $error("discharge enables not updated");

   a_reset_values: assert property (@(posedge clock) disable iff (!reset_n)
      $rose(reset_n) |-> positive_level_code == `RESET_LEVEL_CODE &&
      negative_level_code == `RESET_LEVEL_CODE && application_mode_select)
      else $error("power-up values wrong");

   c_write: cover property (@(posedge clock) disable iff (!reset_n)
      write_strobe);
   c_read_more: cover property (@(posedge scl) disable iff (!link_clear_n)
      phase_reg == lcd_bias_pkg::PHASE_RDATA && ack_clock && master_ack);
   c_foreign: cover property (@(posedge scl) disable iff (!link_clear_n)
      phase_reg == lcd_bias_pkg::PHASE_ADDR && last_bit && !addr_match);

endmodule : lcd_bias_i2c_register_port

`default_nettype wire

// ---- logic/lcd_bias_cfg.svh ----
// constants of the display bias two-wire register port
`ifndef LCD_BIAS_CFG_SVH
`define LCD_BIAS_CFG_SVH

// fixed slave address, bits 7 to 1 of the first byte
`define SLAVE_ADDRESS 7'h73

// register offsets
`define OFFSET_POSITIVE_LEVEL 8'h00
`define OFFSET_NEGATIVE_LEVEL 8'h01
`define OFFSET_DISCHARGE_APP 8'h03

// field positions
`define LEVEL_CODE_MSB 4
`define BIT_POSITIVE_DISCHARGE 1
`define BIT_NEGATIVE_DISCHARGE 0
`define BIT_APPLICATION_MODE 6

// power-up values
`define RESET_LEVEL_CODE 5'h0A
`define RESET_DISCHARGE_APP 8'h43

// bit counter positions within a nine-clock byte
`define LAST_DATA_BIT 4'h7
`define ACK_BIT_INDEX 4'h8

`endif

// ---- logic/lcd_bias_pkg.sv ----
// types of the display bias two-wire register port
package lcd_bias_pkg;

   // byte phases of the link engine
   typedef enum logic [2:0] {
      PHASE_ADDR,
      PHASE_REG,
      PHASE_WDATA,
      PHASE_RD_START,
      PHASE_RDATA,
      PHASE_IGNORE
   } link_phase_t;

endpackage : lcd_bias_pkg

// ---- logic/bit_sync.sv ----
// two flip-flop synchroniser for one level
`timescale 1ns/100ps
`default_nettype none

module bit_sync (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // level in and out
   input wire logic async_in,
   output logic sync_out
);

   logic stage_reg;
   logic sync_reg;

   // first stage feeds only the second
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         stage_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         stage_reg <= async_in;
         sync_reg <= stage_reg;
      end
   end

   assign sync_out = sync_reg;

endmodule : bit_sync

`default_nettype wire

// ---- logic/level_regs.sv ----
// register bank of the display bias supply, system clock side
`timescale 1ns/100ps
`default_nettype none
`include "lcd_bias_cfg.svh"

module level_regs (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // write request
   input wire logic write_strobe,
   input wire logic [7:0] write_offset,
   input wire logic [7:0] write_value,
   // settings
   output logic [4:0] positive_level_code,
   output logic [4:0] negative_level_code,
   output logic positive_discharge_enable,
   output logic negative_discharge_enable,
   output logic application_mode_select
);

   logic [4:0] positive_reg;
   logic [4:0] negative_reg;
   logic pos_dis_reg;
   logic neg_dis_reg;
   logic app_reg;
   wire logic hit_positive;
   wire logic hit_negative;
   wire logic hit_control;
   localparam logic [7:0] CONTROL_RESET = `RESET_DISCHARGE_APP;

   assign hit_positive = write_strobe & (write_offset == `OFFSET_POSITIVE_LEVEL);
   assign hit_negative = write_strobe & (write_offset == `OFFSET_NEGATIVE_LEVEL);
   assign hit_control = write_strobe & (write_offset == `OFFSET_DISCHARGE_APP);

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         positive_reg <= `RESET_LEVEL_CODE;
         negative_reg <= `RESET_LEVEL_CODE;
         pos_dis_reg <= CONTROL_RESET[`BIT_POSITIVE_DISCHARGE];
         neg_dis_reg <= CONTROL_RESET[`BIT_NEGATIVE_DISCHARGE];
         app_reg <= CONTROL_RESET[`BIT_APPLICATION_MODE];
      end else begin
         if (hit_positive) positive_reg <= write_value[`LEVEL_CODE_MSB:0];
         if (hit_negative) negative_reg <= write_value[`LEVEL_CODE_MSB:0];
         if (hit_control) begin
            pos_dis_reg <= write_value[`BIT_POSITIVE_DISCHARGE];
            neg_dis_reg <= write_value[`BIT_NEGATIVE_DISCHARGE];
            app_reg <= write_value[`BIT_APPLICATION_MODE];
         end
      end
   end

   // settings straight from the flops
   assign positive_level_code = positive_reg;
   assign negative_level_code = negative_reg;
   assign positive_discharge_enable = pos_dis_reg;
   assign negative_discharge_enable = neg_dis_reg;
   assign application_mode_select = app_reg;

endmodule : level_regs

`default_nettype wire

// ---- verification/i2c_master_model.sv ----
// two-wire bus master model that drives the bias port's link
`timescale 1ns/100ps
`default_nettype none

module i2c_master_model (
   // link clock and data pull-down
   output logic scl,
   output logic sda_pull,
   // resolved data wire
   input wire logic sda_line
);
   // ****************************************
   // idle bus and framing
   // ****************************************

   // clock stands high and data rests on its pull-up between frames
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   task automatic frame_start();
      if (scl === 1'b0) begin
         #40;
         sda_pull = 1'b0;
         #40;
         scl = 1'b1;
         #80;
      end
      sda_pull = 1'b1;
      #120; // clock held high so the port sees the start first
      scl = 1'b0;
   endtask : frame_start

   task automatic frame_stop();
      #40;
      sda_pull = 1'b1;
      #40;
      scl = 1'b1;
      #120;
      sda_pull = 1'b0;
      #200;
   endtask : frame_stop

   // ****************************************
   // bits and bytes
   // ****************************************

   task automatic put_bit(input logic b, output logic got);
      #40;
      sda_pull = ~b;
      #40;
      scl = 1'b1;
      #40;
      got = sda_line; // sampled mid-high, where the wire is settled
      #40;
      scl = 1'b0;
   endtask : put_bit

   task automatic put_byte(input logic [7:0] v, output logic ack);
      logic got;
      for (int i = 7; i >= 0; i--) begin
         put_bit(v[i], got);
      end
      put_bit(1'b1, got);
      ack = ~got;
   endtask : put_byte

   task automatic get_byte(input logic more, output logic [7:0] v);
      logic got;
      for (int i = 7; i >= 0; i--) begin
         put_bit(1'b1, got);
         v[i] = got;
      end
      put_bit(~more, got);
   endtask : get_byte
endmodule : i2c_master_model
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench of the display bias two-wire register port
`timescale 1ns/100ps
`default_nettype none
`include "lcd_bias_cfg.svh"

module testbench;
   localparam logic [7:0] wr_addr = {`SLAVE_ADDRESS, 1'b0};
   localparam logic [7:0] rd_addr = {`SLAVE_ADDRESS, 1'b1};
   logic clock;
   logic reset_n;
   logic scl;
   logic sda_pull;
   logic sda_in;
   logic sda_out;
   logic sda_oe;
   logic [4:0] positive_level_code;
   logic [4:0] negative_level_code;
   logic positive_discharge_enable;
   logic negative_discharge_enable;
   logic application_mode_select;
   logic ack;
   int err_total;
   int checks_done;

   // wired-and data line with pull-up
   assign sda_in = ~sda_pull & (~sda_oe | sda_out);

   lcd_bias_i2c_register_port lcd_bias_i2c_register_port_inst (
      .clock(clock),
      .reset_n(reset_n),
      .scl(scl),
      .sda_in(sda_in),
      .sda_out(sda_out),
      .sda_oe(sda_oe),
      .positive_level_code(positive_level_code),
      .negative_level_code(negative_level_code),
      .positive_discharge_enable(positive_discharge_enable),
      .negative_discharge_enable(negative_discharge_enable),
      .application_mode_select(application_mode_select)
   );

   i2c_master_model i2c_master_model_inst (
      .scl(scl),
      .sda_pull(sda_pull),
      .sda_line(sda_in)
   );

   // ****************************************
   // shared tasks
   // ****************************************

   // compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp,
         input string what);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t %s: saw %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   // write frame: pointer then a run of data bytes
   task automatic reg_write(input logic [7:0] ptr, input logic [7:0] d [$]);
      logic a;
      i2c_master_model_inst.frame_start();
      i2c_master_model_inst.put_byte(wr_addr, a);
      check({7'h00, a}, 8'h01, "address ack");
      i2c_master_model_inst.put_byte(ptr, a);
      check({7'h00, a}, 8'h01, "pointer ack");
      foreach (d[i]) begin
         i2c_master_model_inst.put_byte(d[i], a);
         check({7'h00, a}, 8'h01, "data ack");
      end
      i2c_master_model_inst.frame_stop();
   endtask : reg_write

   // read frame: pointer, restart, bytes acked but the last
   task automatic reg_read(input logic [7:0] ptr, input logic [7:0] e [$]);
      logic a;
      logic [7:0] v;
      i2c_master_model_inst.frame_start();
      i2c_master_model_inst.put_byte(wr_addr, a);
      check({7'h00, a}, 8'h01, "address ack");
      i2c_master_model_inst.put_byte(ptr, a);
      check({7'h00, a}, 8'h01, "pointer ack");
      i2c_master_model_inst.frame_start();
      i2c_master_model_inst.put_byte(rd_addr, a);
      check({7'h00, a}, 8'h01, "read address ack");
      foreach (e[i]) begin
         i2c_master_model_inst.get_byte(i < e.size() - 1, v);
         check(v, e[i], "read data");
      end
      i2c_master_model_inst.frame_stop();
   endtask : reg_read

   // settings outputs against expected codes and flags
   task automatic outs(input logic [7:0] p, input logic [7:0] n,
         input logic [7:0] f);
      check({3'h0, positive_level_code}, p, "positive code");
      check({3'h0, negative_level_code}, n, "negative code");
      check({5'h00, application_mode_select, positive_discharge_enable,
         negative_discharge_enable}, f, "flags");
   endtask : outs

   // verdict and end of run
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_of_test

   // ****************************************
   // clock, watchdog and tests
   // ****************************************

   // system clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // watchdog well past the expected run of about 60 us
   initial begin
      #300000;
      err_total++;
      $display("[ERR] %0t watchdog expired", $time);
      end_of_test();
   end

   // test sequence
   initial begin
      err_total = 0;
      checks_done = 0;
      reset_n = 1'b0;
      repeat (10) @(posedge clock);
      #1 reset_n = 1'b1;
      repeat (5) @(posedge clock);
      // link edges fall just after system clock edges, never on them
      #1;
      outs(8'h0A, 8'h0A, 8'h07);
      reg_read(8'h00, {8'h0A, 8'h0A, 8'h00, 8'h43});
      // level codes kept within 00h to 14h
      reg_write(8'h00, {8'h14});
      outs(8'h14, 8'h0A, 8'h07);
      reg_write(8'h01, {8'h00});
      outs(8'h14, 8'h00, 8'h07);
      // foreign address stays silent and changes nothing
      i2c_master_model_inst.frame_start();
      i2c_master_model_inst.put_byte({`SLAVE_ADDRESS ^ 7'h01, 1'b0}, ack);
      check({7'h00, ack}, 8'h00, "foreign address ack");
      i2c_master_model_inst.put_byte(8'h00, ack);
      check({7'h00, ack}, 8'h00, "foreign data ack");
      i2c_master_model_inst.frame_stop();
      outs(8'h14, 8'h00, 8'h07);
      reg_write(8'h00, {8'hE5, 8'h13, 8'h7E, 8'hC2});
      outs(8'h05, 8'h13, 8'h06);
      reg_read(8'h00, {8'h05, 8'h13, 8'h00, 8'h42});
      reg_write(8'h03, {8'h01});
      outs(8'h05, 8'h13, 8'h01);
      reg_read(8'h03, {8'h01});
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
